// *** keypad_guard_pkg.sv ***
package keypad_guard_pkg;
    // Register offsets
    localparam logic [7:0] OPEN_STEP1_EVENT_OFS = 8'h33;
    localparam logic [7:0] OPEN_STEP2_EVENT_OFS = 8'h34;
    localparam logic [7:0] EXTERNAL_LOCK_TRIGGER_OFS = 8'h35;
    localparam logic [7:0] OPEN_AND_MASK_TIMING_OFS = 8'h36;
    localparam logic [7:0] KEYPAD_GUARD_CONTROL_OFS = 8'h37;
    // Field positions
    localparam int POLARITY_BIT = 7;
    localparam int CODE_MSB = 6;
    localparam int MASK_TIMER_MSB = 7;
    localparam int MASK_TIMER_LSB = 3;
    localparam int OPEN_WINDOW_MSB = 2;
    localparam int LOCK_ENABLE_BIT = 0;
    // Reset values
    localparam logic [7:0] EVENT_REG_RESET = 8'h00;
    localparam logic [7:0] TIMING_REG_RESET = 8'h00;
    localparam logic LOCK_ENABLE_RESET = 1'b0;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int TIMER_LEN_W = 5;
    // Timer channels
    localparam int CH_WINDOW = 0;
    localparam int CH_MASK = 1;
    localparam int NUM_CH = 2;
    // Guard states
    typedef enum logic [1:0] {ST_OPEN, ST_LOCKED, ST_ARMED} guard_state_t;
endpackage : keypad_guard_pkg

// *** second_timer_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface second_timer_if;
    import keypad_guard_pkg::*;
    logic [NUM_CH-1:0] start;
    logic [NUM_CH-1:0] stop;
    logic [NUM_CH-1:0][TIMER_LEN_W-1:0] len;
    logic [NUM_CH-1:0] busy;
    logic [NUM_CH-1:0] expired;
    modport ctrl (output start, output stop, output len,
                  input busy, input expired);
    modport timer (input start, input stop, input len,
                   output busy, output expired);
endinterface : second_timer_if
`default_nettype wire

// *** second_timers.sv ***
`timescale 1ns/1ns
`default_nettype none
module second_timers #(
    parameter int TICK_CYCLES = keypad_guard_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Timer channels
    second_timer_if.timer tif
);
    import keypad_guard_pkg::*;

    localparam int CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] CYC_LAST = CW'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("second_timers: TICK_CYCLES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////
    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        logic [CW-1:0] cyc_reg;
        logic [TIMER_LEN_W-1:0] sec_reg;
        logic busy_reg;
        logic exp_reg;
        // Each channel divides mclk into whole seconds from its own start
        always_ff @(posedge mclk) begin
            if (sys_rst || tif.stop[g]) begin
                busy_reg <= 1'b0;
                exp_reg <= 1'b0;
                cyc_reg <= '0;
                sec_reg <= '0;
            end else begin
                exp_reg <= 1'b0;
                if (tif.start[g] && (tif.len[g] != '0)) begin
                    busy_reg <= 1'b1;
                    cyc_reg <= '0;
                    sec_reg <= '0;
                end else if (busy_reg) begin
                    if (cyc_reg == CYC_LAST) begin
                        cyc_reg <= '0;
                        if (sec_reg + 1'b1 == tif.len[g]) begin
                            busy_reg <= 1'b0;
                            exp_reg <= 1'b1;
                        end else begin
                            sec_reg <= sec_reg + 1'b1;
                        end
                    end else begin
                        cyc_reg <= cyc_reg + 1'b1;
                    end
                end
            end
        end
        assign tif.busy[g] = busy_reg;
        assign tif.expired[g] = exp_reg;
    end
endmodule : second_timers
`default_nettype wire

// *** keypad_guard.sv ***
// Summary of operation
// - First open-step register code is the first event needed to unlock.
// - Bit 7 picks matching state; key press matches only with bit 7 set, releases never match.
// - For GPI/logic events bit 7 picks inactive (0) or active (1).
// - Second open-step code is the event needed after the first.
// - Matching external lock event locks keypad and pulses lock interrupt.
// - External lock bit 7 uses the same state encoding as open steps.
// - Locked with nonzero mask field: an event may raise event interrupt.
// - Mask timer then runs 1-31 s, blocking interrupts until expiry/unlock.
// - Window timeout or any other event between steps returns to lock.
// - Window field: 000 no limit, 001-111 give 1 to 7 seconds.
// - Control bit 0 enables locking; bits 7:1 reserved, read zero.
`timescale 1ns/1ns
`default_nettype none
module keypad_guard #(
    parameter int TICK_CYCLES = keypad_guard_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    // Event stream
    input wire logic evt_valid,
    input wire logic [keypad_guard_pkg::CODE_MSB:0] evt_code,
    input wire logic evt_state,
    input wire logic evt_is_key,
    // Status
    output logic keypad_locked,
    output logic event_irq,
    output logic lock_irq
);
    import keypad_guard_pkg::*;

    logic [7:0] step1_reg;
    logic [7:0] step2_reg;
    logic [7:0] trigger_reg;
    logic [7:0] timing_reg;
    logic lock_en_reg;
    guard_state_t state_reg;
    logic [7:0] rd_next;
    logic hit1;
    logic hit2;
    logic hit_trig;
    logic is_locked;
    logic unlock_now;
    logic lock_en_rise;

    // Refuse a time base that the second timers cannot count
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("keypad_guard: TICK_CYCLES must be at least 2");
    end

    second_timer_if tif ();

    second_timers #(.TICK_CYCLES(TICK_CYCLES)) u_timers (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////
    // Event match: code equal and state as selected by bit 7
    function automatic logic ev_match(input logic [7:0] cfg,
                                      input logic [CODE_MSB:0] code,
                                      input logic st,
                                      input logic is_key);
        logic pol;
        pol = cfg[POLARITY_BIT];
        if (code != cfg[CODE_MSB:0]) begin
            ev_match = 1'b0;
        end else if (is_key) begin
            ev_match = pol && st;
        end else begin
            ev_match = (st == pol);
        end
    endfunction : ev_match

    assign hit1 = evt_valid && ev_match(step1_reg, evt_code, evt_state,
                                        evt_is_key);
    assign hit2 = evt_valid && ev_match(step2_reg, evt_code, evt_state,
                                        evt_is_key);
    assign hit_trig = evt_valid && ev_match(trigger_reg, evt_code,
                                            evt_state, evt_is_key);
    assign is_locked = (state_reg != ST_OPEN);
    assign unlock_now = (state_reg == ST_ARMED) && hit2;
    assign lock_en_rise = reg_wr_en && (reg_addr == KEYPAD_GUARD_CONTROL_OFS)
        && reg_wdata[LOCK_ENABLE_BIT] && !lock_en_reg;

    ////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            step1_reg <= EVENT_REG_RESET;
            step2_reg <= EVENT_REG_RESET;
            trigger_reg <= EVENT_REG_RESET;
            timing_reg <= TIMING_REG_RESET;
            lock_en_reg <= LOCK_ENABLE_RESET;
        end else if (reg_wr_en) begin
            case (reg_addr)
                OPEN_STEP1_EVENT_OFS: step1_reg <= reg_wdata;
                OPEN_STEP2_EVENT_OFS: step2_reg <= reg_wdata;
                EXTERNAL_LOCK_TRIGGER_OFS: trigger_reg <= reg_wdata;
                OPEN_AND_MASK_TIMING_OFS: timing_reg <= reg_wdata;
                KEYPAD_GUARD_CONTROL_OFS: begin
                    lock_en_reg <= reg_wdata[LOCK_ENABLE_BIT];
                end
                default: ;
            endcase
        end
    end

    // Register read mux; reserved and unmapped read as zero
    always_comb begin
        case (reg_addr)
            OPEN_STEP1_EVENT_OFS: rd_next = step1_reg;
            OPEN_STEP2_EVENT_OFS: rd_next = step2_reg;
            EXTERNAL_LOCK_TRIGGER_OFS: rd_next = trigger_reg;
            OPEN_AND_MASK_TIMING_OFS: rd_next = timing_reg;
            KEYPAD_GUARD_CONTROL_OFS: rd_next = {7'h0, lock_en_reg};
            default: rd_next = 8'h00;
        endcase
    end

    // Registered read answer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rd_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lock state machine
    // A cleared enable wins over any event in the same cycle, so a
    // host can always force the keypad open. A first step seen again while
    // armed counts as a stray event and relocks instead of re-arming.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= ST_OPEN;
        end else if (!lock_en_reg && !lock_en_rise) begin
            state_reg <= ST_OPEN;
        end else begin
            case (state_reg)
                ST_OPEN: begin
                    if (lock_en_rise || hit_trig) begin
                        state_reg <= ST_LOCKED;
                    end
                end
                ST_LOCKED: begin
                    if (hit1) begin
                        state_reg <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (hit2) begin
                        state_reg <= ST_OPEN;
                    end else if (evt_valid || tif.expired[CH_WINDOW]) begin
                        state_reg <= ST_LOCKED;
                    end
                end
                default: state_reg <= ST_OPEN;
            endcase
        end
    end

    // Timer control: window on first step, mask on an allowed interrupt
    always_comb begin
        tif.len[CH_WINDOW] = {2'b00, timing_reg[OPEN_WINDOW_MSB:0]};
        tif.len[CH_MASK] = timing_reg[MASK_TIMER_MSB:MASK_TIMER_LSB];
        tif.start[CH_WINDOW] = (state_reg == ST_LOCKED) && hit1
            && lock_en_reg;
        tif.stop[CH_WINDOW] = (state_reg != ST_ARMED) && !tif.start[CH_WINDOW];
        tif.start[CH_MASK] = is_locked && evt_valid && !unlock_now
            && !tif.busy[CH_MASK];
        tif.stop[CH_MASK] = unlock_now || !is_locked;
    end

    ////////////////////////////////////////////////////////////////////
    // Locked status, one cycle behind the state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            keypad_locked <= 1'b0;
        end else begin
            keypad_locked <= is_locked;
        end
    end

    // Event interrupt, held back while locked and the mask timer runs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            event_irq <= 1'b0;
        end else begin
            event_irq <= evt_valid
                && !(is_locked && tif.busy[CH_MASK]);
        end
    end

    // Lock interrupt, only for the trigger event while enabled and open
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lock_irq <= 1'b0;
        end else begin
            lock_irq <= lock_en_reg && (state_reg == ST_OPEN)
                && hit_trig;
        end
    end
endmodule : keypad_guard
`default_nettype wire

// *** keypad_guard_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module keypad_guard_sva
    import keypad_guard_pkg::*;
(
    // Clock and reset
    input wire logic mclk, sys_rst,
    // Register port
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic reg_wr_en, reg_rd_en, reg_rdata_valid,
    // Events and status
    input wire logic evt_valid, keypad_locked, event_irq, lock_irq
);
    // Control register accesses
    wire logic ctl_wr = reg_wr_en && reg_addr == KEYPAD_GUARD_CONTROL_OFS;
    wire logic ctl_rd = reg_rd_en && reg_addr == KEYPAD_GUARD_CONTROL_OFS;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Keypad held locked with no second lock pulse
    sequence s_held;
        keypad_locked && !lock_irq;
    endsequence
    property p_rda; reg_rd_en |=> reg_rdata_valid; endproperty
    a_rda: assert property (p_rda) else $error("no read answer");
    property p_rdq; !reg_rd_en |=> !reg_rdata_valid; endproperty
    a_rdq: assert property (p_rdq) else $error("stray answer");
    property p_rsv; ctl_rd |=> reg_rdata[7:1] == 7'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_unm;
        reg_rd_en && reg_addr > 8'h37 |=> reg_rdata == 8'h00;
    endproperty
    a_unm: assert property (p_unm) else $error("hole not zero");
    // Enable lands, state opens, then the registered status follows
    property p_off;
        ctl_wr && !reg_wdata[0] |-> ##3 !keypad_locked;
    endproperty
    a_off: assert property (p_off) else $error("not opened");
    property p_lock; lock_irq |-> $past(evt_valid) ##1 s_held; endproperty
    a_lock: assert property (p_lock) else $error("bad lock");
    property p_cause; event_irq |-> $past(evt_valid); endproperty
    a_cause: assert property (p_cause) else $error("irq no event");
    // Open keypad: every non-locking event interrupts
    property p_open;
        evt_valid && !keypad_locked ##1 !keypad_locked && !lock_irq
            |-> event_irq;
    endproperty
    a_open: assert property (p_open) else $error("open no irq");
endmodule : keypad_guard_sva
bind keypad_guard keypad_guard_sva chk_u (.*);
`default_nettype wire

// *** keypad_event_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module keypad_event_source (
    // Clock
    input wire logic mclk,
    // Event stream toward the block
    output logic evt_valid, evt_state, evt_is_key,
    output logic [keypad_guard_pkg::CODE_MSB:0] evt_code
);
    import keypad_guard_pkg::*;
    // Quiet stream at time zero
    initial {evt_valid, evt_state, evt_is_key, evt_code} = '0;
    // One event for one cycle, then the inverse so no stale copy remains
    task automatic send(input logic [7:0] ev, input logic key);
        @(posedge mclk) #1;
        evt_valid = 1'b1;
        {evt_state, evt_code} = ev;
        evt_is_key = key;
        @(posedge mclk) #1;
        evt_valid = 1'b0;
        {evt_state, evt_code} = ~ev;
    endtask : send
endmodule : keypad_event_source
`default_nettype wire

// *** keypad_guard_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module keypad_guard_bench;
    import keypad_guard_pkg::*;
    localparam int TICK = 10;
    localparam logic [7:0] BASE = OPEN_STEP1_EVENT_OFS;
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_rdata_valid, keypad_locked, event_irq, lock_irq;
    logic evt_valid, evt_state, evt_is_key;
    logic [CODE_MSB:0] evt_code;
    int fail_count = 0, comparisons = 0;
    // Register image: steps, trigger, timing (mask 2 s, window 3 s), control
    logic [7:0] vals [5] = '{8'h85, 8'h12, 8'h40, 8'h13, 8'hFF};
    initial forever #20 mclk = ~mclk;
    keypad_guard #(.TICK_CYCLES(TICK)) dut_u (.*);
    keypad_event_source src_u (.*);
    // Comparison and counting
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #1;
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk) #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge mclk) #1;
        reg_rd_en = 1'b0;
        check(reg_rdata, exp);
        check({7'h00, reg_rdata_valid}, 8'h01);
    endtask : rd
    // Event with both interrupt pulses looked at in the answer cycle
    task automatic ev(input logic [7:0] e, input logic key, input logic [1:0] x);
        src_u.send(e, key);
        check({6'h00, event_irq, lock_irq}, {6'h00, x});
    endtask : ev
    task automatic lck(input logic exp);
        @(posedge mclk) #1;
        check({7'h00, keypad_locked}, {7'h00, exp});
    endtask : lck
    task automatic tally_and_finish;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(BASE + 8'(i), 8'h00);
            wr(BASE + 8'(i), vals[i]);
            rd(BASE + 8'(i), i == 4 ? 8'h01 : vals[i]);
        end
        rd(8'h38, 8'h00);
        $display("registers done");
        lck(1'b1);
        ev(8'h05, 1'b1, 2'h2);
        ev(8'h85, 1'b1, 2'h0);
        ev(8'h12, 1'b0, 2'h0);
        lck(1'b0);
        ev(8'h40, 1'b1, 2'h2);
        ev(8'hC0, 1'b0, 2'h2);
        ev(8'h40, 1'b0, 2'h3);
        lck(1'b1);
        $display("open pair and trigger done");
        wr(KEYPAD_GUARD_CONTROL_OFS, 8'h00);
        wr(KEYPAD_GUARD_CONTROL_OFS, 8'h01);
        ev(8'h85, 1'b1, 2'h2);
        repeat (3 * TICK + 2) @(posedge mclk);
        ev(8'h12, 1'b0, 2'h2);
        lck(1'b1);
        $display("window expiry done");
        wr(OPEN_AND_MASK_TIMING_OFS, 8'h03);
        wr(KEYPAD_GUARD_CONTROL_OFS, 8'h00);
        wr(KEYPAD_GUARD_CONTROL_OFS, 8'h01);
        ev(8'h85, 1'b1, 2'h2);
        ev(8'h07, 1'b1, 2'h2);
        ev(8'h12, 1'b0, 2'h2);
        lck(1'b1);
        $display("stray event done");
        tally_and_finish();
    end
endmodule : keypad_guard_bench
`default_nettype wire
